// ==== verilog/cslp_pkg.sv ====
package cslp_pkg;

  // Bus levels on the receive line
  localparam logic LEVEL_DOMINANT  = 1'b0;
  localparam logic LEVEL_RECESSIVE = 1'b1;

  // Recessive bits needed before leaving sleep
  localparam int  WAKE_RUN_BITS = 11;
  localparam int  RUN_CNT_W     = 4;

  localparam logic [RUN_CNT_W-1:0] RUN_CNT_RESET = 4'h0;
  localparam logic [RUN_CNT_W-1:0] RUN_CNT_LAST  = 4'(WAKE_RUN_BITS - 1);

  // Reset values of the outputs and of the rearm register
  localparam logic SLEEP_FLAG_RESET = 1'b0;
  localparam logic AUTO_WAKE_RESET  = 1'b0;
  localparam logic REARM_RESET      = 1'b1;

  typedef enum logic [1:0] {
    CSLP_AWAKE    = 2'b00,
    CSLP_ENTERING = 2'b01,
    CSLP_ASLEEP   = 2'b10,
    CSLP_WAKING   = 2'b11
  } cslp_state_t;

  // Controls coming from the controller control register
  typedef struct packed {
    logic sleep_request;
    logic auto_wakeup_enable;
  } cslp_ctrl_t;

  // Bus-side view from the bit timing and protocol logic
  typedef struct packed {
    logic can_rx;
    logic sample_point;
    logic frame_busy;
  } cslp_bus_t;

endpackage : cslp_pkg

// ==== verilog/cslp_sleep_ctrl.sv ====
`timescale 1ns/1ps

module cslp_sleep_ctrl (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              reset_n,
  // Control bits
  input  wire cslp_pkg::cslp_ctrl_t ctrl,
  // Bus view
  input  wire cslp_pkg::cslp_bus_t  bus,
  // Status
  output logic                   sleep_state_flag,
  output logic                   auto_wake_pulse
);

  cslp_pkg::cslp_state_t         state;
  cslp_pkg::cslp_state_t         next_state;
  logic [cslp_pkg::RUN_CNT_W-1:0] run_cnt;
  logic [cslp_pkg::RUN_CNT_W-1:0] next_run_cnt;
  logic                          rearm;
  logic                          next_rearm;

  wire logic rx_dominant   = (bus.can_rx == cslp_pkg::LEVEL_DOMINANT);
  wire logic rx_recessive  = (bus.can_rx == cslp_pkg::LEVEL_RECESSIVE);
  wire logic enter_ok      = ctrl.sleep_request && rearm;
  wire logic bus_activity  = ctrl.auto_wakeup_enable && rx_dominant;
  wire logic run_done      = bus.sample_point && rx_recessive
                             && (run_cnt == cslp_pkg::RUN_CNT_LAST);
  wire logic auto_wake_now = (state == cslp_pkg::CSLP_ASLEEP) && ctrl.sleep_request
                             && bus_activity;
  wire logic next_flag     = (next_state == cslp_pkg::CSLP_ASLEEP)
                             || (next_state == cslp_pkg::CSLP_WAKING);

  always_comb begin
    next_state = state;
    unique case (state)
      cslp_pkg::CSLP_AWAKE: begin
        if (enter_ok && !bus.frame_busy) begin
          next_state = cslp_pkg::CSLP_ASLEEP;
        end else if (enter_ok) begin
          next_state = cslp_pkg::CSLP_ENTERING;
        end
      end
      cslp_pkg::CSLP_ENTERING: begin
        if (!ctrl.sleep_request) begin
          next_state = cslp_pkg::CSLP_AWAKE;
        end else if (!bus.frame_busy) begin
          next_state = cslp_pkg::CSLP_ASLEEP;
        end
      end
      cslp_pkg::CSLP_ASLEEP: begin
        if (!ctrl.sleep_request || bus_activity) begin
          next_state = cslp_pkg::CSLP_WAKING;
        end
      end
      cslp_pkg::CSLP_WAKING: begin
        if (run_done) begin
          next_state = cslp_pkg::CSLP_AWAKE;
        end
      end
    endcase
  end

  // Recessive run counter; any dominant sample restarts it
  always_comb begin
    next_run_cnt = run_cnt;
    if (state == cslp_pkg::CSLP_ASLEEP) begin
      next_run_cnt = cslp_pkg::RUN_CNT_RESET;
    end else if (state == cslp_pkg::CSLP_WAKING && bus.sample_point) begin
      if (rx_dominant || run_done) begin
        next_run_cnt = cslp_pkg::RUN_CNT_RESET;
      end else begin
        next_run_cnt = run_cnt + 4'h1;
      end
    end
  end

  // After an automatic wake the request must drop before sleep is entered again
  always_comb begin
    next_rearm = rearm;
    if (!ctrl.sleep_request) begin
      next_rearm = 1'b1;
    end else if (auto_wake_now) begin
      next_rearm = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state <= cslp_pkg::CSLP_AWAKE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      run_cnt <= cslp_pkg::RUN_CNT_RESET;
      rearm   <= cslp_pkg::REARM_RESET;
    end else begin
      run_cnt <= next_run_cnt;
      rearm   <= next_rearm;
    end
  end

  // Flag tracks the sleep states only; no software path clears it
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sleep_state_flag <= cslp_pkg::SLEEP_FLAG_RESET;
      auto_wake_pulse  <= cslp_pkg::AUTO_WAKE_RESET;
    end else begin
      sleep_state_flag <= next_flag;
      auto_wake_pulse  <= auto_wake_now;
    end
  end

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  sequence seq_asleep_activity;
    (state == cslp_pkg::CSLP_ASLEEP) && ctrl.auto_wakeup_enable && rx_dominant;
  endsequence

  sequence seq_last_recessive;
    (state == cslp_pkg::CSLP_WAKING) && bus.sample_point && rx_recessive
    && (run_cnt == cslp_pkg::RUN_CNT_LAST);
  endsequence

  chk_flag_needs_req: assert property (
    $rose(sleep_state_flag) |-> $past(ctrl.sleep_request))
    else $error("sleep flag rose without a sleep request");

  chk_entry_after_frame: assert property (
    $rose(sleep_state_flag) |-> !$past(bus.frame_busy))
    else $error("sleep entered while a frame was in progress");

  chk_busy_holds_off: assert property (
    (state == cslp_pkg::CSLP_ENTERING) && bus.frame_busy |=> !sleep_state_flag)
    else $error("sleep flag set during a frame");

  chk_flag_fall_run: assert property (
    $fell(sleep_state_flag) |-> $past(run_cnt) == cslp_pkg::RUN_CNT_LAST
                                && $past(bus.sample_point) && $past(bus.can_rx))
    else $error("sleep flag cleared before eleven recessive bits");

  chk_flag_fall_wake: assert property (
    $fell(sleep_state_flag) |-> $past(state) == cslp_pkg::CSLP_WAKING
                                && state == cslp_pkg::CSLP_AWAKE)
    else $error("sleep flag cleared outside the wake sequence");

  chk_withdraw_wakes: assert property (
    (state == cslp_pkg::CSLP_ASLEEP) && !ctrl.sleep_request
    |=> state == cslp_pkg::CSLP_WAKING ##0 sleep_state_flag)
    else $error("withdrawn request did not start wake-up");

  chk_auto_wake: assert property (
    seq_asleep_activity and (ctrl.sleep_request)
    |=> auto_wake_pulse && state == cslp_pkg::CSLP_WAKING)
    else $error("bus activity did not start automatic wake-up");

  chk_flag_state: assert property (
    sleep_state_flag == ((state == cslp_pkg::CSLP_ASLEEP)
                         || (state == cslp_pkg::CSLP_WAKING)))
    else $error("sleep flag disagrees with sleep state");

  chk_count_restart: assert property (
    seq_asleep_activity |=> run_cnt == cslp_pkg::RUN_CNT_RESET)
    else $error("recessive count not restarted on activity");

  chk_run_leaves: assert property (
    seq_last_recessive |=> !sleep_state_flag ##1 1'b1)
    else $error("eleventh recessive bit did not end sleep");

  // Sample points seen while counting recessive bits
  sequence seq_waking_sample;
    (state == cslp_pkg::CSLP_WAKING) && bus.sample_point;
  endsequence

  chk_entry_prompt: assert property (
    (state == cslp_pkg::CSLP_AWAKE) && ctrl.sleep_request && rearm && !bus.frame_busy
    |=> sleep_state_flag && state == cslp_pkg::CSLP_ASLEEP)
    else $error("idle bus did not let sleep be entered");

  chk_entry_deferred: assert property (
    (state == cslp_pkg::CSLP_ENTERING) && ctrl.sleep_request && !bus.frame_busy
    |=> sleep_state_flag)
    else $error("sleep not entered once the frame ended");

  chk_entry_withdrawn: assert property (
    (state == cslp_pkg::CSLP_ENTERING) && !ctrl.sleep_request
    |=> state == cslp_pkg::CSLP_AWAKE && !sleep_state_flag)
    else $error("withdrawn request still entered sleep");

  chk_rearm_blocks: assert property (
    (state == cslp_pkg::CSLP_AWAKE) && !rearm |=> !sleep_state_flag)
    else $error("sleep entered again before the request was dropped");

  chk_pulse_single: assert property (
    auto_wake_pulse |=> !auto_wake_pulse)
    else $error("wake pulse longer than one cycle");

  chk_waking_holds: assert property (
    (state == cslp_pkg::CSLP_WAKING) && (run_cnt != cslp_pkg::RUN_CNT_LAST)
    |=> sleep_state_flag)
    else $error("sleep flag cleared before the recessive run ended");

  chk_dominant_restart: assert property (
    seq_waking_sample ##0 rx_dominant |=> run_cnt == cslp_pkg::RUN_CNT_RESET)
    else $error("dominant sample did not restart the recessive count");

  chk_count_step: assert property (
    seq_waking_sample ##0 (rx_recessive && (run_cnt != cslp_pkg::RUN_CNT_LAST))
    |=> run_cnt == $past(run_cnt) + 4'h1)
    else $error("recessive sample did not advance the count");

endmodule : cslp_sleep_ctrl

// ==== verif/cslp_bus_model.sv ====
`timescale 1ns/1ps
module cslp_bus_model (
  // Clock and reset
  input  wire logic           clk_sys,
  input  wire logic           reset_n,
  // Bench commands
  input  wire logic           dom_req,
  input  wire logic           busy_req,
  // Bus view
  output cslp_pkg::cslp_bus_t bus
);
  logic [1:0] phase;
  // Sample point every fourth cycle; idle bus rests recessive
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      phase <= 2'h0;
      bus   <= 3'h4;
    end else begin
      phase            <= phase + 2'h1;
      bus.sample_point <= (phase == 2'h3);
      bus.can_rx       <= dom_req ? cslp_pkg::LEVEL_DOMINANT : cslp_pkg::LEVEL_RECESSIVE;
      bus.frame_busy   <= busy_req;
    end
  end
endmodule : cslp_bus_model

// ==== verif/tb_cslp_sleep_ctrl.sv ====
`timescale 1ns/1ps
module tb_cslp_sleep_ctrl;
  logic                 clk_sys;
  logic                 reset_n;
  cslp_pkg::cslp_ctrl_t ctrl;
  cslp_pkg::cslp_bus_t  bus;
  logic                 dom_req;
  logic                 busy_req;
  logic                 sleep_state_flag;
  logic                 auto_wake_pulse;
  logic [15:0]          rnd;
  int                   failures;
  int                   checks_done;
  int                   pulses = 0;
  int                   exp_pulses;

  cslp_sleep_ctrl u_dut (.clk_sys(clk_sys), .reset_n(reset_n), .ctrl(ctrl), .bus(bus),
    .sleep_state_flag(sleep_state_flag), .auto_wake_pulse(auto_wake_pulse));
  cslp_bus_model u_bus (.clk_sys(clk_sys), .reset_n(reset_n), .dom_req(dom_req),
    .busy_req(busy_req), .bus(bus));

  function automatic logic [15:0] next_rnd(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : next_rnd

  task automatic stop_test();
    if (failures == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic wait_sp(input int n);
    int k;
    repeat (n) begin
      k = 0;
      do begin
        @(posedge clk_sys);
        k++;
      end while (bus.sample_point !== 1'b1 && k < 10);
      if (k >= 10) begin
        check("sample_point", 16'h0001, 16'h0000);
        stop_test();
      end
    end
  endtask : wait_sp

  // Level change lands just after a sample point, so the next n samples see it
  task automatic bits(input logic dom, input int n);
    dom_req <= dom;
    wait_sp(n);
  endtask : bits

  task automatic wait_flag(input logic lvl, input int lim);
    int k;
    k = 0;
    do begin
      @(posedge clk_sys);
      #1;
      k++;
    end while (sleep_state_flag !== lvl && k < lim);
    check("sleep_state_flag", {15'h0000, lvl}, {15'h0000, sleep_state_flag});
    if (sleep_state_flag !== lvl) begin
      stop_test();
    end
  endtask : wait_flag

  always @(posedge clk_sys) begin
    if (auto_wake_pulse === 1'b1) begin
      pulses <= pulses + 1;
    end
  end

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  initial begin
    reset_n = 1'b0;
    ctrl = 2'h0;
    dom_req = 1'b0;
    busy_req = 1'b0;
    rnd = 16'hF61C;
    failures = 0;
    checks_done = 0;
    exp_pulses = 0;
    repeat (6) @(posedge clk_sys);
    reset_n <= 1'b1;
    // Request withdrawn while a frame runs: sleep is never entered
    @(posedge clk_sys);
    busy_req <= 1'b1;
    @(posedge clk_sys);
    ctrl <= 2'h2;
    repeat (4) @(posedge clk_sys);
    ctrl <= 2'h0;
    @(posedge clk_sys);
    busy_req <= 1'b0;
    repeat (4) @(posedge clk_sys);
    #1;
    check("flag after withdrawn entry", 16'h0000, {15'h0000, sleep_state_flag});
    for (int r = 0; r < 6; r++) begin
      rnd = next_rnd(rnd);
      @(posedge clk_sys);
      busy_req <= 1'b1;
      // The model registers busy, so it must stand before the request is seen
      @(posedge clk_sys);
      ctrl <= {1'b1, rnd[5]};
      repeat (3 + rnd[2:0]) @(posedge clk_sys);
      #1;
      check("flag while busy", 16'h0000, {15'h0000, sleep_state_flag});
      @(posedge clk_sys);
      busy_req <= 1'b0;
      wait_flag(1'b1, 4);
      wait_sp(1);
      if (r[0]) begin
        ctrl.auto_wakeup_enable <= 1'b1;
        exp_pulses++;
        bits(1'b1, 1 + rnd[4:3]);
        bits(1'b0, 6);
        bits(1'b1, 1);
      end else begin
        ctrl.sleep_request <= 1'b0;
      end
      bits(1'b0, 10);
      #1;
      check("flag during count", 16'h0001, {15'h0000, sleep_state_flag});
      wait_sp(1);
      wait_flag(1'b0, 3);
      check("wake pulses", exp_pulses[15:0], pulses[15:0]);
      repeat (4) @(posedge clk_sys);
      #1;
      check("flag after wake", 16'h0000, {15'h0000, sleep_state_flag});
      @(posedge clk_sys);
      ctrl <= 2'h0;
    end
    stop_test();
  end
endmodule : tb_cslp_sleep_ctrl
